// [core/smbus_bit_sampler.v]
/*
  pin conditioning for the smbus slave: two-flop synchronisers on the
  serial clock and data pins, plus edge, start and stop detection.
  assumes scl_in and sda_in are asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none

module smbus_bit_sampler (
  // clock and reset
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  // raw pins
  input wire scl_in,
  input wire sda_in,
  // conditioned outputs
  output wire scl_rise,
  output wire scl_fall,
  output wire start_seen,
  output wire stop_seen,
  output wire sda_level,
  output wire scl_level
);

  reg [1:0] scl_sync_ff; // [0] is the metastable stage, read only by [1]
  reg [1:0] sda_sync_ff;
  reg scl_prev_ff; // previous settled scl
  reg sda_prev_ff; // previous settled sda

  // synchronise and remember last value; bus idles high after reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else if (clk_en) begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  assign scl_level = scl_sync_ff[1];
  assign sda_level = sda_sync_ff[1];
  assign scl_rise = clk_en & scl_sync_ff[1] & ~scl_prev_ff;
  assign scl_fall = clk_en & ~scl_sync_ff[1] & scl_prev_ff;
  // data moving while scl high marks start or stop
  assign start_seen = clk_en & scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
  assign stop_seen = clk_en & scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];

endmodule // smbus_bit_sampler

`default_nettype wire

// [core/smbus_slave_defs.vh]
/*
  constants for the smbus slave pointer interface: bus addresses,
  register offsets, field positions, reset values and timeout figures.
  assumes it is included by bare name from files under core/.
*/
`ifndef SMBUS_SLAVE_DEFS_VH
`define SMBUS_SLAVE_DEFS_VH

// bus addresses (7 bit)
`define OWN_ADDR 7'h2E
`define ALERT_RESP_ADDR 7'h0C

// register map
`define CONFIG_ONE_OFFSET 8'h40
`define CONFIG_ONE_RESET 8'h00
`define BUS_TIMEOUT_OFF_BIT 6

// bits per byte on the wire, ack follows
`define BITS_PER_BYTE 4'h8

// bus timeout
`define TIMEOUT_MS 35
`define CLK_KHZ 25000
`define TIMEOUT_CYCLES (`TIMEOUT_MS * `CLK_KHZ)

`endif

// [core/smbus_slave_pointer_interface.v]
/*
  smbus slave with an address pointer: send byte, write byte, receive
  byte, alert response and bus timeout. holds the first configuration
  register; every other register lives outside behind reg_* ports.
  assumes the host drives scl and a pull-up resolves sda from sda_oe.
*/
// Notes on behaviour
// - answer own address 0x2E, and 0x0C while alert asserted, bit eight rw
// - nine clocks per byte, msb first, ack
// - data changes only while clock low
// - direction fixed by rw bit at start
// - first write byte loads the pointer
// - second write byte stores to selected register
// - read returns one byte at current pointer
// - send byte changes only the pointer
// - repeated start after pointer write serves read
// - ack address, command and first data byte; later bytes not acked
// - alert asserted: answer response address with ours
// - arbitrate during alert response, lowest wins
// - alert released only when condition gone
// - 35 ms idle with timeout on: release, idle
// - config bit 6 disables timeout, default 0
`timescale 1ns/1ns
`default_nettype none
`include "smbus_slave_defs.vh"

module smbus_slave_pointer_interface #(
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES // shorten in simulation
) (
  // clock, reset, enable
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  // serial bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // alert: condition from the monitor, open-drain style output
  input wire alert_cond,
  output reg alert_n_ff,
  // outside register file
  output reg [7:0] reg_addr_ff,
  output reg [7:0] reg_wdata_ff,
  output reg reg_wr_ff,
  input wire [7:0] reg_rdata,
  // configuration state
  output wire bus_timeout_off_bit,
  output reg timeout_hit_ff
);

  // bus phases
  localparam ST_IDLE = 3'h0; // waiting for start
  localparam ST_ADDR = 3'h1; // shifting address byte
  localparam ST_ACK = 3'h2; // our ack slot (receiving)
  localparam ST_WRX = 3'h3; // shifting written byte
  localparam ST_TX = 3'h4; // shifting read byte out
  localparam ST_MACK = 3'h5; // master ack slot after read byte
  localparam ST_IGNORE = 3'h6; // not ours, or extra bytes

  localparam integer TO_LAST_INT = TIMEOUT_CYCLES - 1;
  localparam [26:0] TO_LAST = TO_LAST_INT[26:0]; // idle counter is 27 bits wide

  wire scl_rise, scl_fall, start_seen, stop_seen, sda_level;

  smbus_bit_sampler u_sampler (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_level(sda_level),
    // bus clock level unused: its edges carry all the timing here
    .scl_level()
  );

  reg [2:0] state_ff, nxt_state; // bus phase
  reg [3:0] bit_cnt_ff, nxt_bit_cnt; // bits done in current byte
  reg [7:0] shift_ff, nxt_shift; // receive / transmit shifter
  reg [1:0] byte_cnt_ff, nxt_byte_cnt; // write bytes after address
  reg is_read_ff, nxt_is_read; // direction latched at address
  reg is_ara_ff, nxt_is_ara; // current read is alert response
  reg drive_low_ff, nxt_drive_low; // pulls sda low
  reg lost_ff, nxt_lost; // lost arbitration during alert reply
  reg [7:0] config_one_ff; // first configuration register
  reg [26:0] idle_cnt_ff; // cycles without bus activity
  reg ptr_load, data_store; // one-cycle strobes

  assign sda_out = 1'b0; // open drain: only ever pull low
  assign sda_oe = drive_low_ff;
  assign bus_timeout_off_bit = config_one_ff[`BUS_TIMEOUT_OFF_BIT];

  // read data: own config register or the outside file
  wire [7:0] rd_byte = (reg_addr_ff == `CONFIG_ONE_OFFSET) ? config_one_ff : reg_rdata;
  wire [6:0] rx_addr = shift_ff[7:1]; // bus address once eight bits are in
  wire [7:0] ara_reply = {`OWN_ADDR, 1'b1}; // our address with the read bit
  wire timeout_fire = ~bus_timeout_off_bit & (state_ff != ST_IDLE) &
                      (idle_cnt_ff == TO_LAST);

  // bus phase sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_is_read = is_read_ff;
    nxt_is_ara = is_ara_ff;
    nxt_drive_low = drive_low_ff;
    nxt_lost = lost_ff;
    ptr_load = 1'b0;
    data_store = 1'b0;
    if (timeout_fire) begin
      // bus stuck: let go of sda and wait for a fresh start
      nxt_state = ST_IDLE;
      nxt_drive_low = 1'b0;
    end else if (start_seen) begin
      // start or repeated start restarts address reception, unless a timeout fires in the same cycle
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_drive_low = 1'b0;
      nxt_lost = 1'b0;
    end else if (stop_seen) begin
      nxt_state = ST_IDLE;
      nxt_drive_low = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_drive_low = 1'b0;
        end
        ST_ADDR, ST_WRX: begin
          if (scl_rise) begin
            // msb first
            nxt_shift = {shift_ff[6:0], sda_level};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == `BITS_PER_BYTE) begin
            nxt_bit_cnt = 4'h0;
            if (state_ff == ST_ADDR) begin
              nxt_is_read = shift_ff[0];
              nxt_byte_cnt = 2'h0;
              if (rx_addr == `OWN_ADDR) begin
                nxt_is_ara = 1'b0;
                nxt_state = ST_ACK;
                nxt_drive_low = 1'b1;
              end else if (rx_addr == `ALERT_RESP_ADDR && !alert_n_ff && shift_ff[0]) begin
                nxt_is_ara = 1'b1;
                nxt_state = ST_ACK;
                nxt_drive_low = 1'b1;
              end else begin
                nxt_state = ST_IGNORE;
              end
            end else begin
              // written byte complete
              nxt_byte_cnt = byte_cnt_ff + 2'h1;
              if (byte_cnt_ff == 2'h0) begin
                ptr_load = 1'b1;
                nxt_state = ST_ACK;
                nxt_drive_low = 1'b1;
              end else if (byte_cnt_ff == 2'h1) begin
                data_store = 1'b1;
                nxt_state = ST_ACK;
                nxt_drive_low = 1'b1;
              end else begin
                nxt_state = ST_IGNORE;
              end
            end
          end
        end
        ST_ACK: begin
          // ack held across the ninth clock, released on its fall
          if (scl_fall) begin
            nxt_drive_low = 1'b0;
            if (is_read_ff) begin
              // reply: own address for alert response, else pointer data
              nxt_shift = is_ara_ff ? ara_reply : rd_byte;
              nxt_drive_low = is_ara_ff ? ~ara_reply[7] : ~rd_byte[7];
              nxt_state = ST_TX;
            end else begin
              nxt_state = ST_WRX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            // arbitration: we released but bus is low, another wins
            if (!drive_low_ff && !sda_level && is_ara_ff) begin
              nxt_lost = 1'b1;
            end
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (lost_ff) begin
              // a lower address won: stay silent for the rest of this reply
              nxt_drive_low = 1'b0;
              nxt_state = ST_IGNORE;
            end else if (bit_cnt_ff == `BITS_PER_BYTE) begin
              nxt_drive_low = 1'b0;
              nxt_bit_cnt = 4'h0;
              nxt_state = ST_MACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_drive_low = ~shift_ff[6];
            end
          end
        end
        ST_MACK: begin
          // single byte reads only: whatever the master answers, stop sending
          if (scl_fall) begin
            nxt_state = ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          // hands off until the next start or stop; extra write bytes land here
          nxt_drive_low = 1'b0;
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_drive_low = 1'b0;
        end
      endcase
    end
  end

  // phase registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byte_cnt_ff <= 2'h0;
      is_read_ff <= 1'b0;
      is_ara_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      lost_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      byte_cnt_ff <= nxt_byte_cnt;
      is_read_ff <= nxt_is_read;
      is_ara_ff <= nxt_is_ara;
      drive_low_ff <= nxt_drive_low;
      lost_ff <= nxt_lost;
    end
  end

  // pointer, register writes; pointer survives aborted transfers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_addr_ff <= 8'h00;
      reg_wdata_ff <= 8'h00;
      reg_wr_ff <= 1'b0;
      config_one_ff <= `CONFIG_ONE_RESET;
    end else if (clk_en) begin
      reg_wr_ff <= 1'b0;
      if (ptr_load) begin
        reg_addr_ff <= shift_ff;
      end
      if (data_store) begin
        reg_wdata_ff <= shift_ff;
        reg_wr_ff <= (reg_addr_ff != `CONFIG_ONE_OFFSET);
        if (reg_addr_ff == `CONFIG_ONE_OFFSET) begin
          config_one_ff <= shift_ff;
        end
      end
    end
  end

  // inactivity counter: clock edges, start and stop are activity; idle state holds it at zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_ff <= 27'h0000000;
      timeout_hit_ff <= 1'b0;
    end else if (clk_en) begin
      timeout_hit_ff <= timeout_fire;
      if (scl_rise || scl_fall || start_seen || stop_seen || state_ff == ST_IDLE) begin
        idle_cnt_ff <= 27'h0000000;
      end else if (idle_cnt_ff != TO_LAST) begin
        // saturates: with the timeout off the count parks instead of wrapping
        idle_cnt_ff <= idle_cnt_ff + 27'h0000001;
      end
    end
  end

  // alert follows the live condition, so it drops once the cause clears
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_n_ff <= 1'b1;
    end else if (clk_en) begin
      alert_n_ff <= ~alert_cond;
    end
  end

endmodule // smbus_slave_pointer_interface

`default_nettype wire

// [dv/smbus_master_model.sv]
/* smbus master model: bit-banged clock and open-drain data drive.
   assumes a pull-up outside resolves sda from all drivers. */
`timescale 1ns/1ns
`default_nettype none
module smbus_master_model (
  // bench clock: each bit or condition starts 1 ns after its rising edge
  input wire logic clk,
  // bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial scl = 1'b1;
  initial sda_drv = 1'b1;
  // clock low 200 ns, high 120 ns; data moves mid-low only
  task automatic bit_io(input logic b, output logic q);
    @(posedge clk) #1 scl = 1'b0;
    #80 sda_drv = b;
    #120 scl = 1'b1;
    #80 q = sda;
  endtask
  // start (a=1,z=0) or stop (a=0,z=1): data moves while clock high
  task automatic cond(input logic a, input logic z);
    @(posedge clk) #1 scl = 1'b0;
    #80 sda_drv = a;
    #120 scl = 1'b1;
    #120 sda_drv = z;
    #120;
  endtask
  // eight bits msb first, ninth clock released; ack is 8'h01 when pulled
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic [7:0] ack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], q);
      r[i] = q;
    end
    bit_io(1'b1, q); // a released ninth bit is the read not-acknowledge
    ack = {7'h00, ~q};
  endtask
endmodule // smbus_master_model
`default_nettype wire

// [dv/smbus_slave_pointer_interface_props.sv]
/* assertions on the smbus slave pins and register strobes.
   assumes the bus clock low phase spans at least five clk cycles. */
`timescale 1ns/1ns
`default_nettype none
module smbus_slave_pointer_interface_props #(
  parameter TIMEOUT_CYCLES = 875000 // handed on from the design
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // alert, register side, timeout
  input wire logic alert_cond,
  input wire logic alert_n_ff,
  input wire logic [7:0] reg_addr_ff,
  input wire logic reg_wr_ff,
  input wire logic bus_timeout_off_bit,
  input wire logic timeout_hit_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_drive_low_only: assert property (sda_out == 1'b0) else $error("sda drive not low");
  a_pull_clock_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_alert_follows: assert property (clk_en |=> alert_n_ff == !$past(alert_cond))
    else $error("alert output wrong");
  a_config_internal: assert property (reg_wr_ff |-> reg_addr_ff != 8'h40)
    else $error("config write leaked out");
  a_write_single: assert property (reg_wr_ff |=> !reg_wr_ff) else $error("write strobe long");
  a_pointer_not_data: assert property ($changed(reg_addr_ff) |-> !reg_wr_ff ##1 !reg_wr_ff)
    else $error("pointer byte written as data");
  a_timeout_frees: assert property (timeout_hit_ff |-> ##[0:1] !sda_oe ##1 !timeout_hit_ff)
    else $error("timeout kept sda");
  a_timeout_off: assert property ($past(bus_timeout_off_bit) && bus_timeout_off_bit |->
    !timeout_hit_ff) else $error("timeout while disabled");
  // cycles since the raw bus clock last moved, capped at the timeout
  logic scl_last_ff;
  int quiet_cnt_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_last_ff <= 1'b1;
      quiet_cnt_ff <= 0;
    end else if (clk_en) begin
      scl_last_ff <= scl_in;
      if (scl_in != scl_last_ff) quiet_cnt_ff <= 0;
      else if (quiet_cnt_ff < TIMEOUT_CYCLES) quiet_cnt_ff <= quiet_cnt_ff + 1;
    end
  end
  a_timeout_not_early: assert property (timeout_hit_ff |-> quiet_cnt_ff >= TIMEOUT_CYCLES)
    else $error("timeout before bus went quiet");
  c_write: cover property (reg_wr_ff);
  c_timeout: cover property (timeout_hit_ff);
  c_alert: cover property ($fell(alert_n_ff));
endmodule // smbus_slave_pointer_interface_props
bind smbus_slave_pointer_interface smbus_slave_pointer_interface_props #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .alert_cond(alert_cond),
  .alert_n_ff(alert_n_ff), .reg_addr_ff(reg_addr_ff), .reg_wr_ff(reg_wr_ff),
  .bus_timeout_off_bit(bus_timeout_off_bit), .timeout_hit_ff(timeout_hit_ff));
`default_nettype wire

// [dv/smbus_slave_pointer_interface_tb.sv]
/* bench for the smbus slave pointer interface: a master model drives the
   bus, a byte array stands in for the outside registers.
   assumes a 25 MHz clock and a shortened bus timeout. */
`timescale 1ns/1ns
`default_nettype none
module smbus_slave_pointer_interface_tb;
  localparam int TMO = 2000; // short timeout keeps the run brief
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic alert_cond = 1'b0;
  logic scl, sda_drv, sda_oe, sda_out, alert_n_ff, reg_wr_ff, toff, timeout_hit_ff;
  logic [7:0] reg_addr_ff, reg_wdata_ff, ack, rd, p, d;
  logic [7:0] ext_mem [256]; // outside registers
  logic [7:0] exp_mem [256]; // expected contents, 0x40 is config_one
  logic [7:0] bad [3] = '{8'h5E, 8'h19, 8'h1C}; // foreign, alert without alert
  logic [31:0] seed = 32'h2714;
  int error_cnt = 0, comparisons = 0, cycles = 0, hits = 0, wr_cnt = 0, n;
  wire logic sda = sda_drv & ~sda_oe; // pull-up wins when nobody pulls
  always #20 clk = ~clk;
  smbus_slave_pointer_interface #(.TIMEOUT_CYCLES(TMO)) i_dut (.clk(clk), .reset_n(reset_n),
    .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_cond(alert_cond), .alert_n_ff(alert_n_ff), .reg_addr_ff(reg_addr_ff),
    .reg_wdata_ff(reg_wdata_ff), .reg_wr_ff(reg_wr_ff), .reg_rdata(ext_mem[reg_addr_ff]),
    .bus_timeout_off_bit(toff), .timeout_hit_ff(timeout_hit_ff));
  smbus_master_model i_master (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  // outside register file, timeout pulse count and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reg_wr_ff === 1'b1) ext_mem[reg_addr_ff] <= reg_wdata_ff;
    if (reg_wr_ff === 1'b1) wr_cnt <= wr_cnt + 1;
    if (timeout_hit_ff === 1'b1) hits <= hits + 1;
    if (cycles == 30000) begin
      error_cnt++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one byte out, acknowledge compared
  task automatic snd(input logic [7:0] b, input logic [7:0] e);
    i_master.byte_io(b, rd, ack);
    check("ack", ack, e);
  endtask
  // write transfer of k bytes after the address; stop only when s is set
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input int k, input logic s);
    i_master.cond(1'b1, 1'b0);
    snd(8'h5C, 8'h01);
    snd(a, 8'h01);
    if (k > 1) snd(v, 8'h01);
    if (k > 2) snd(~v, 8'h00);
    if (s) i_master.cond(1'b0, 1'b1);
    if (k > 1) exp_mem[a] = v;
    check("pointer", reg_addr_ff, a);
  endtask
  // read transfer at bus byte a, one byte expected
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_master.cond(1'b1, 1'b0);
    snd(a, 8'h01);
    i_master.byte_io(8'hFF, rd, ack);
    check("read data", rd, e);
    i_master.cond(1'b0, 1'b1);
  endtask
  // address acked, then the bus is left hanging past the timeout
  task automatic stall(input logic [7:0] e);
    n = hits;
    snd(8'h00, 8'h00);
    i_master.cond(1'b1, 1'b0);
    snd(8'h5C, 8'h01);
    repeat (TMO + 100) @(posedge clk);
    #7 check("timeouts", 8'(hits - n), e);
    i_master.cond(1'b0, 1'b1);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) begin
      ext_mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #7 check("timeout bit", {7'h00, toff}, 8'h00);
    // random write byte, then send byte and repeated-start read back
    repeat (4) begin
      seed = lfsr(seed);
      p = seed[7:0];
      d = seed[15:8];
      wr(p, d, 2, 1'b1);
      wr(p, 8'h00, 1, 1'b0);
      rd_chk(8'h5D, exp_mem[p]);
    end
    n = wr_cnt;
    wr(8'h22, 8'hA5, 3, 1'b1);
    wr(8'h10, 8'h00, 1, 1'b1);
    check("writes", 8'(wr_cnt - n), 8'h01);
    rd_chk(8'h5D, exp_mem[8'h10]);
    // start in mid byte abandons it and keeps the pointer
    i_master.cond(1'b1, 1'b0);
    snd(8'h5C, 8'h01);
    repeat (4) i_master.bit_io(1'b0, ack[0]);
    check("kept pointer", reg_addr_ff, 8'h10);
    rd_chk(8'h5D, exp_mem[8'h10]);
    wr(8'h22, 8'h00, 1, 1'b0);
    rd_chk(8'h5D, 8'hA5);
    foreach (bad[i]) begin
      i_master.cond(1'b1, 1'b0);
      snd(bad[i], 8'h00);
      i_master.cond(1'b0, 1'b1);
    end
    @(posedge clk) #1 alert_cond = 1'b1;
    repeat (2) @(posedge clk);
    #7 check("alert", {7'h00, alert_n_ff}, 8'h00);
    // a lower address answers the alert response too: we must back off
    i_master.cond(1'b1, 1'b0);
    snd(8'h19, 8'h01);
    i_master.byte_io(8'h5B, rd, ack);
    check("arbitration", rd, 8'h5B);
    i_master.cond(1'b0, 1'b1);
    rd_chk(8'h19, 8'h5D);
    @(posedge clk) #1 alert_cond = 1'b0;
    repeat (2) @(posedge clk);
    #7 check("alert", {7'h00, alert_n_ff}, 8'h01);
    wr(8'h40, 8'h40, 2, 1'b1);
    check("timeout bit", {7'h00, toff}, 8'h01);
    stall(8'h00);
    wr(8'h40, 8'h00, 2, 1'b1);
    stall(8'h01);
    rd_chk(8'h5D, 8'h00);
    test_done();
  end
endmodule // smbus_slave_pointer_interface_tb
`default_nettype wire
